/* File: verilog/vme_slave_cycle_decoder.sv */
// slave-side cycle decoder and responder for the backplane bus
// Functional notes
// RULE1: address, modifier and qualifiers are latched at the falling edge of the address strobe.
// RULE2: upper strobe qualifies bits 8 to 15, lower strobe bits 0 to 7.
// RULE3: write line low means write into the board, high means read.
// RULE4: acknowledge only after read data is valid or write data accepted.
// RULE5: bus error is driven low to report a failed transfer.
// RULE6: longword low with acknowledge high goes to ram/eprom as 32-bit access.
// RULE7: in acknowledge cycles address bits 1 to 3 carry the level, compared.
// RULE8: acknowledge chain passed on when the acknowledged interrupt is not ours.
// RULE9: our acknowledge cycle gets its vector from interrupter on bits 0 to 7.
// RULE10: modifiers 09, 0A, 0D, 0E decode 32-bit addresses to the sockets.
// RULE11: modifier 16 fetches from eprom quadrant 1, 1E from quadrant 2.
// RULE12: short i/o modifiers 29, 2D select peripherals, byte lane 0 only.
// RULE13: modifiers 39, 3A, 3D, 3E select sockets, ignoring address bits 24-31.
// RULE14: system reset clears all board logic; the slave_mem store and its read data register are not reset.
// RULE15: the bus clock is supplied by the system as timing reference.
// RULE16: slave only; 8, 16, 32-bit data, 24 or 32-bit addressing.
// RULE17: strobe timer raises bus error after selected 2-160 us, or off.
// RULE18: cycles outside the decode map are ignored, nothing driven; the bus timer, when on, still drives bus error on them.
// RULE19: acknowledge and data released once both data strobes are high.
`timescale 1ns/1ns
`default_nettype none
`include "vme_slave_consts.svh"
module vme_slave_cycle_decoder
    import vme_slave_pkg::*;
#(
    parameter int          MEM_AW   = 12,
    parameter logic [31:0] EXT_BASE = 32'h0000_0000,
    parameter logic [23:0] STD_BASE = 24'h0000_0000,
    parameter logic [7:0]  SIO_PAGE = 8'hFF
) (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire vme_in_t     vme,
    input  wire logic [2:0]  tmo_sel,
    input  wire logic [2:0]  irq_level,
    input  wire logic        irq_pending,
    input  wire per_in_t     per_in,
    output var  per_out_t    per_out,
    output var  logic [31:0] data_o,
    output var  logic [3:0]  data_oe_n,
    output var  logic        dtack_oe_n,
    output var  logic        berr_oe_n,
    output var  logic        iackout_n
);
    typedef struct packed {
        cyc_state_t           st;
        logic                 as_q;
        logic [31:1]          a;
        logic [5:0]           am;
        logic                 iack;
        logic                 lword;
        logic                 wr;
        logic [1:0]           ds;
        logic                 half;
        logic [`TMO_W-1:0]    tmr;
        logic [31:0]          dout;
        logic [3:0]           oe_n;
        logic                 dtack_oe_n;
        logic                 berr_oe_n;
        logic                 iackout_n;
        per_out_t             per;
        logic                 mem_we;
        logic [3:0]           mem_be;
        logic [MEM_AW-1:0]    mem_addr;
        logic [31:0]          mem_wdata;
    } core_state_t;

    core_state_t s;
    core_state_t next_s;
    logic [31:0] mem_rdata;
    logic [`TMO_W-1:0] tmo_limit;
    logic is_ext;
    logic is_std;
    logic is_quad;
    logic is_sio;
    logic hit_mem;
    logic hit_sio;
    logic [1:0] quad;
    logic [3:0] lanes;

    slave_mem #(
        .AW (MEM_AW)
    ) u_mem (
        .core_clk (core_clk),
        .we       (s.mem_we),
        .be       (s.mem_be),
        .addr     (s.mem_addr),
        .wdata    (s.mem_wdata),
        .rdata    (mem_rdata)
    );

    // timeout choices, zero means the timer is off
    always_comb begin
        case (tmo_sel)
            3'd1:    tmo_limit = `TMO_W'(`TMO_SEL1_CYC);
            3'd2:    tmo_limit = `TMO_W'(`TMO_SEL2_CYC);
            3'd3:    tmo_limit = `TMO_W'(`TMO_SEL3_CYC);
            3'd4:    tmo_limit = `TMO_W'(`TMO_SEL4_CYC);
            3'd5:    tmo_limit = `TMO_W'(`TMO_SEL5_CYC);
            3'd6:    tmo_limit = `TMO_W'(`TMO_SEL6_CYC);
            3'd7:    tmo_limit = `TMO_W'(`TMO_SEL7_CYC);
            default: tmo_limit = '0;
        endcase
    end

    // decode of the latched cycle
    always_comb begin
        is_ext  = (s.am == `AM_EXT_A) || (s.am == `AM_EXT_B) ||
                  (s.am == `AM_EXT_C) || (s.am == `AM_EXT_D);
        is_std  = (s.am == `AM_STD_A) || (s.am == `AM_STD_B) ||
                  (s.am == `AM_STD_C) || (s.am == `AM_STD_D);
        is_quad = (s.am == `AM_QUAD1) || (s.am == `AM_QUAD2);
        is_sio  = (s.am == `AM_SIO_A) || (s.am == `AM_SIO_B);
        quad    = `QUAD2_SEL;
        if (s.am == `AM_QUAD1) begin
            quad = `QUAD1_SEL; // RULE11
        end
        hit_mem = 1'b0;
        if (!s.iack) begin
            if (is_ext && s.a[31:MEM_AW+2] == EXT_BASE[31:MEM_AW+2]) begin
                hit_mem = 1'b1; // RULE10
            end
            if (is_std && s.a[23:MEM_AW+2] == STD_BASE[23:MEM_AW+2]) begin
                hit_mem = 1'b1; // RULE13
            end
            if (is_quad) begin
                hit_mem = 1'b1; // RULE11
            end
        end
        // short i/o answers only on its page and never as a longword
        hit_sio = 1'b0;
        if (!s.iack && !s.lword && is_sio && s.a[15:8] == SIO_PAGE) begin
            hit_sio = 1'b1; // RULE12
        end
        // 32-bit words on all lanes, otherwise the strobes pick the lanes
        if (s.lword) begin
            lanes = 4'hF; // RULE6
        end else begin
            lanes = {2'b00, s.ds}; // RULE2
        end
    end

    always_comb begin
        next_s            = s;
        next_s.as_q       = vme.as_n;
        next_s.per.req    = 1'b0;
        next_s.mem_we     = 1'b0;

        // bus timer runs on any strobe, whether or not this board is selected
        if (&vme.ds_n) begin
            next_s.tmr       = '0; // RULE17
            next_s.berr_oe_n = 1'b1;
        end else if (tmo_limit != '0) begin
            if (s.tmr >= tmo_limit - `TMO_W'(1)) begin
                next_s.berr_oe_n = 1'b0; // RULE5 RULE17
            end else begin
                next_s.tmr = s.tmr + `TMO_W'(1);
            end
        end

        case (s.st)
            ST_IDLE: begin
                next_s.dtack_oe_n = 1'b1;
                next_s.oe_n       = 4'hF;
                next_s.iackout_n  = 1'b1;
                if (s.as_q && !vme.as_n) begin
                    next_s.a     = vme.addr; // RULE1
                    next_s.am    = vme.am;
                    next_s.iack  = !vme.iack_n;
                    next_s.lword = !vme.lword_n;
                    next_s.st    = ST_DECODE;
                end
            end
            ST_DECODE: begin
                if (vme.as_n) begin
                    next_s.st = ST_IDLE;
                end else if (!(&vme.ds_n)) begin
                    next_s.wr   = !vme.write_n; // RULE3
                    next_s.ds   = ~vme.ds_n;
                    next_s.half = s.a[1];
                    if (s.iack) begin
                        if (s.a[3:1] == irq_level && irq_pending && !vme.iackin_n) begin
                            next_s.per.req   = 1'b1; // RULE7 RULE9
                            next_s.per.iack  = 1'b1;
                            next_s.per.we    = 1'b0;
                            next_s.per.addr  = {5'h00, s.a[3:1]};
                            next_s.wr        = 1'b0;
                            next_s.st        = ST_PER;
                        end else begin
                            next_s.st = ST_PASS; // RULE8
                        end
                    end else if (hit_mem) begin
                        next_s.mem_addr = is_quad ?
                            {quad, s.a[MEM_AW-1:2]} : s.a[MEM_AW+1:2]; // RULE11 RULE16
                        next_s.mem_we   = !vme.write_n;
                        if (s.lword) begin
                            next_s.mem_be    = 4'hF; // RULE6
                            next_s.mem_wdata = vme.data;
                        end else begin
                            // the even half-word sits in the upper memory lanes
                            if (s.a[1]) begin
                                next_s.mem_be = {2'b00, ~vme.ds_n}; // RULE2
                            end else begin
                                next_s.mem_be = {~vme.ds_n, 2'b00}; // RULE2
                            end
                            next_s.mem_wdata = {vme.data[15:0], vme.data[15:0]};
                        end
                        next_s.st = ST_MEM;
                    end else if (hit_sio) begin
                        next_s.per.req   = 1'b1; // RULE12
                        next_s.per.iack  = 1'b0;
                        next_s.per.we    = !vme.write_n;
                        // a lone lower strobe addresses the odd byte
                        next_s.per.addr  = {s.a[7:1], vme.ds_n[1]};
                        next_s.per.wdata = vme.data[7:0];
                        next_s.st        = ST_PER;
                    end else begin
                        next_s.st = ST_DONE; // RULE18
                    end
                end
            end
            ST_MEM: begin
                // write landed on this edge; a read needs one more for the data register
                next_s.st = s.wr ? ST_ACK : ST_MRD;
            end
            ST_MRD: begin
                if (s.lword) begin
                    next_s.dout = mem_rdata;
                end else begin
                    next_s.dout = {16'h0000, s.half ? mem_rdata[15:0] : mem_rdata[31:16]};
                end
                next_s.st = ST_ACK;
            end
            ST_PER: begin
                // no local limit: a silent peripheral is ended by the bus timer
                if (per_in.ack) begin
                    next_s.dout = {24'h00_0000, per_in.rdata}; // RULE9 RULE12
                    next_s.st   = ST_ACK;
                end
            end
            ST_ACK: begin
                next_s.dtack_oe_n = 1'b0; // RULE4
                // vectors and short i/o use lane 0 only; writes never drive the data lines
                if (!s.wr && (s.iack || !hit_mem)) begin
                    next_s.oe_n = 4'hE; // RULE9 RULE12
                end else if (!s.wr) begin
                    next_s.oe_n = ~lanes; // RULE2
                end
                if (&vme.ds_n) begin
                    next_s.dtack_oe_n = 1'b1; // RULE19
                    next_s.oe_n       = 4'hF;
                    next_s.st         = ST_IDLE;
                end
            end
            ST_PASS: begin
                next_s.iackout_n = vme.iackin_n; // RULE8
                if (vme.as_n) begin
                    next_s.iackout_n = 1'b1;
                    next_s.st        = ST_IDLE;
                end
            end
            ST_DONE: begin
                next_s.dtack_oe_n = 1'b1; // RULE18
                next_s.oe_n       = 4'hF;
                if (&vme.ds_n) begin
                    next_s.st = ST_IDLE;
                end
            end
            default: begin
                next_s.st = ST_IDLE;
            end
        endcase

        // a timed-out cycle is abandoned; bus error stands until the strobes rise
        if (!next_s.berr_oe_n && s.st != ST_IDLE && s.st != ST_PASS) begin
            next_s.st         = ST_DONE; // RULE5
            next_s.dtack_oe_n = 1'b1;
            next_s.oe_n       = 4'hF;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            s            <= '0; // RULE14
            s.st         <= ST_IDLE;
            // strobe history starts high so an address strobe already low as reset ends is taken as a fall
            s.as_q       <= 1'b1;
            s.oe_n       <= 4'hF;
            s.dtack_oe_n <= 1'b1;
            s.berr_oe_n  <= 1'b1;
            s.iackout_n  <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign per_out    = s.per;
    assign data_o     = s.dout;
    assign data_oe_n  = s.oe_n;
    assign dtack_oe_n = s.dtack_oe_n;
    assign berr_oe_n  = s.berr_oe_n;
    assign iackout_n  = s.iackout_n;
endmodule : vme_slave_cycle_decoder
`default_nettype wire

/* File: verilog/vme_slave_consts.svh */
// constants of the backplane slave cycle decoder
`ifndef VME_SLAVE_CONSTS_SVH
`define VME_SLAVE_CONSTS_SVH

`define CLK_MHZ          10
`define TMO_SEL1_US      2
`define TMO_SEL2_US      8
`define TMO_SEL3_US      16
`define TMO_SEL4_US      32
`define TMO_SEL5_US      64
`define TMO_SEL6_US      128
`define TMO_SEL7_US      160
`define TMO_SEL1_CYC     (`TMO_SEL1_US * `CLK_MHZ)
`define TMO_SEL2_CYC     (`TMO_SEL2_US * `CLK_MHZ)
`define TMO_SEL3_CYC     (`TMO_SEL3_US * `CLK_MHZ)
`define TMO_SEL4_CYC     (`TMO_SEL4_US * `CLK_MHZ)
`define TMO_SEL5_CYC     (`TMO_SEL5_US * `CLK_MHZ)
`define TMO_SEL6_CYC     (`TMO_SEL6_US * `CLK_MHZ)
`define TMO_SEL7_CYC     (`TMO_SEL7_US * `CLK_MHZ)
`define TMO_W            11

`define AM_EXT_A         6'h09
`define AM_EXT_B         6'h0A
`define AM_EXT_C         6'h0D
`define AM_EXT_D         6'h0E
`define AM_QUAD1         6'h16
`define AM_QUAD2         6'h1E
`define AM_SIO_A         6'h29
`define AM_SIO_B         6'h2D
`define AM_STD_A         6'h39
`define AM_STD_B         6'h3A
`define AM_STD_C         6'h3D
`define AM_STD_D         6'h3E
`define QUAD1_SEL        2'h1
`define QUAD2_SEL        2'h2

`endif

/* File: verilog/vme_slave_pkg.sv */
// types of the backplane slave cycle decoder
package vme_slave_pkg;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_DECODE = 3'b001,
        ST_MEM    = 3'b011,
        ST_MRD    = 3'b010,
        ST_ACK    = 3'b110,
        ST_PER    = 3'b111,
        ST_PASS   = 3'b101,
        ST_DONE   = 3'b100
    } cyc_state_t;

    typedef struct packed {
        logic        as_n;
        logic [1:0]  ds_n;
        logic        write_n;
        logic        lword_n;
        logic        iack_n;
        logic        iackin_n;
        logic [5:0]  am;
        logic [31:1] addr;
        logic [31:0] data;
    } vme_in_t;

    typedef struct packed {
        logic       ack;
        logic [7:0] rdata;
    } per_in_t;

    typedef struct packed {
        logic       req;
        logic       we;
        logic       iack;
        logic [7:0] addr;
        logic [7:0] wdata;
    } per_out_t;

endpackage : vme_slave_pkg

/* File: verilog/slave_mem.sv */
// on-board ram/eprom socket store with registered read data
`timescale 1ns/1ns
`default_nettype none
module slave_mem #(
    parameter int AW = 12
) (
    input  wire logic          core_clk,
    input  wire logic          we,
    input  wire logic [3:0]    be,
    input  wire logic [AW-1:0] addr,
    input  wire logic [31:0]   wdata,
    output var  logic [31:0]   rdata
);
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            // one array per lane, so each lane's writes stay inside a single process
            logic [7:0] lane_store [0:(1<<AW)-1];
            always_ff @(posedge core_clk) begin
                if (we && be[g]) begin
                    lane_store[addr] <= wdata[8*g +: 8];
                end
                rdata[8*g +: 8] <= lane_store[addr];
            end
        end
    endgenerate
endmodule : slave_mem
`default_nettype wire

/* File: test/vme_slave_cycle_decoder_assertions.sv */
// concurrent checks on the ports of the backplane slave cycle decoder
`timescale 1ns/1ns
`default_nettype none
`include "vme_slave_consts.svh"
module vme_slave_cycle_decoder_assertions
    import vme_slave_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        reset,
    input wire vme_in_t     vme,
    input wire logic [2:0]  tmo_sel,
    input wire logic [2:0]  irq_level,
    input wire logic        irq_pending,
    input wire per_in_t     per_in,
    input wire per_out_t    per_out,
    input wire logic [31:0] data_o,
    input wire logic [3:0]  data_oe_n,
    input wire logic        dtack_oe_n,
    input wire logic        berr_oe_n,
    input wire logic        iackout_n
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // qualifiers latched at the address strobe fall, as the decoder sees them
    logic       as_q;
    logic       lw_q;
    logic       ik_q;
    logic [5:0] am_q;
    int         cnt;
    int         lims [8] = '{0, `TMO_SEL1_CYC, `TMO_SEL2_CYC, `TMO_SEL3_CYC, `TMO_SEL4_CYC, `TMO_SEL5_CYC,
                             `TMO_SEL6_CYC, `TMO_SEL7_CYC};
    wire sio = ik_q && am_q inside {`AM_SIO_A, `AM_SIO_B};
    wire mapped = !ik_q || sio && lw_q || am_q inside {`AM_EXT_A, `AM_EXT_B, `AM_EXT_C, `AM_EXT_D,
        `AM_QUAD1, `AM_QUAD2, `AM_STD_A, `AM_STD_B, `AM_STD_C, `AM_STD_D};
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            as_q <= 1'b1;
            lw_q <= 1'b1;
            ik_q <= 1'b1;
            am_q <= 6'h00;
            cnt  <= 0;
        end else begin
            as_q <= vme.as_n;
            if (as_q && !vme.as_n) begin
                am_q <= vme.am;
                lw_q <= vme.lword_n;
                ik_q <= vme.iack_n;
            end
            cnt <= (&vme.ds_n) ? 0 : cnt + 1;
        end
    end
    property p_release; &vme.ds_n [*2] |=> dtack_oe_n && berr_oe_n && &data_oe_n; endproperty
    a_release: assert property (p_release) else $error("drivers held after strobes released");
    property p_ack_cause; $fell(dtack_oe_n) |-> !(&$past(vme.ds_n)) && !$past(vme.as_n); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("acknowledge without strobes");
    property p_map; !dtack_oe_n |-> mapped; endproperty
    a_map: assert property (p_map) else $error("acknowledge on unmapped cycle");
    property p_sio_lane; !dtack_oe_n && sio |-> data_oe_n[3:1] == 3'b111; endproperty
    a_sio_lane: assert property (p_sio_lane) else $error("short io drove upper lanes");
    property p_vector; !dtack_oe_n && !ik_q && !vme.as_n |-> vme.addr[3:1] == irq_level && data_oe_n == 4'hE;
    endproperty
    a_vector: assert property (p_vector) else $error("vector cycle level or lanes wrong");
    property p_chain; !iackout_n |-> !$past(vme.iackin_n) && !ik_q; endproperty
    a_chain: assert property (p_chain) else $error("chain passed without acknowledge in");
    property p_write; !dtack_oe_n && !vme.write_n |-> &data_oe_n; endproperty
    a_write: assert property (p_write) else $error("data driven on write");
    property p_lanes;
        !dtack_oe_n && vme.write_n && ik_q && !sio && !(&vme.ds_n) |-> data_oe_n == (lw_q ? {2'b11, vme.ds_n} : 4'h0);
    endproperty
    a_lanes: assert property (p_lanes) else $error("read lanes do not follow strobes");
    property p_timer; $fell(berr_oe_n) |-> tmo_sel != 3'd0 && cnt inside {[lims[tmo_sel] - 3 : lims[tmo_sel] + 3]};
    endproperty
    a_timer: assert property (p_timer) else $error("bus error at wrong time");
    property p_reset; disable iff (1'b0) reset |-> dtack_oe_n && berr_oe_n && iackout_n && &data_oe_n && !per_out.req;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs active in reset");
    c_ack: cover property ($fell(dtack_oe_n));
    c_berr: cover property ($fell(berr_oe_n));
    c_chain: cover property ($fell(iackout_n));
endmodule : vme_slave_cycle_decoder_assertions
bind vme_slave_cycle_decoder vme_slave_cycle_decoder_assertions vme_slave_cycle_decoder_assertions_inst (.core_clk,
    .reset, .vme, .tmo_sel, .irq_level, .irq_pending, .per_in, .per_out, .data_o, .data_oe_n, .dtack_oe_n,
    .berr_oe_n, .iackout_n);
`default_nettype wire

/* File: test/vme_bus_master.sv */
// bus master model that runs one backplane cycle per call
`timescale 1ns/1ns
`default_nettype none
module vme_bus_master
    import vme_slave_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        dtack_oe_n,
    input  wire logic        berr_oe_n,
    input  wire logic        iackout_n,
    input  wire logic [3:0]  data_oe_n,
    input  wire logic [31:0] data_o,
    output var  vme_in_t     vme
);
    initial vme = {7'h7F, 69'h0};
    // c = {iack_n, lword_n, write_n, ds_n}; res 0 acknowledge, 1 bus error, 2 nothing
    task automatic cycle(input logic [5:0] am, input logic [31:0] a, input logic [4:0] c, input logic [31:0] w,
                         input int lim, output int res, output int n, output logic [36:0] rd);
        res = 2;
        n = 0;
        @(posedge core_clk);
        vme.am      <= am;
        vme.addr    <= a[31:1];
        vme.iack_n  <= c[4];
        vme.lword_n <= c[3];
        @(posedge core_clk);
        vme.as_n     <= 1'b0;
        vme.iackin_n <= c[4];
        @(posedge core_clk);
        vme.write_n <= c[2];
        vme.ds_n    <= c[1:0];
        vme.data    <= w;
        while (res == 2 && n < lim) begin
            @(posedge core_clk);
            n++;
            rd = {iackout_n, data_oe_n, data_o};
            if (!dtack_oe_n) res = 0;
            else if (!berr_oe_n) res = 1;
        end
        // released lines show the inverse, never the stale value
        vme.ds_n     <= 2'b11;
        vme.as_n     <= 1'b1;
        vme.iackin_n <= 1'b1;
        vme.data     <= ~w;
        vme.addr     <= ~a[31:1];
        for (int k = 0; k < 8 && !(dtack_oe_n && berr_oe_n && iackout_n); k++) @(posedge core_clk);
        repeat (2) @(posedge core_clk);
    endtask : cycle
endmodule : vme_bus_master
`default_nettype wire

/* File: test/tb_vme_slave_cycle_decoder.sv */
// directed testbench for the backplane slave cycle decoder
`timescale 1ns/1ns
`default_nettype none
`include "vme_slave_consts.svh"
module tb_vme_slave_cycle_decoder;
    import vme_slave_pkg::*;
    logic        core_clk;
    logic        reset;
    logic        irq_pending;
    logic [2:0]  tmo_sel;
    logic [2:0]  irq_level;
    vme_in_t     vme;
    per_in_t     per_in;
    per_out_t    per_out;
    per_out_t    per_q;
    logic [31:0] data_o;
    logic [3:0]  data_oe_n;
    logic        dtack_oe_n;
    logic        berr_oe_n;
    logic        iackout_n;
    logic [36:0] rd;
    int          res;
    int          n;
    int          fail_count = 0;
    int          comparisons = 0;
    vme_slave_cycle_decoder vme_slave_cycle_decoder_inst (.core_clk, .reset, .vme, .tmo_sel, .irq_level,
        .irq_pending, .per_in, .per_out, .data_o, .data_oe_n, .dtack_oe_n, .berr_oe_n, .iackout_n);
    vme_bus_master vme_bus_master_inst (.core_clk, .dtack_oe_n, .berr_oe_n, .iackout_n, .data_oe_n, .data_o, .vme);
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // peripheral answers one edge after each request
    always @(posedge core_clk) begin
        per_in <= {per_out.req, 8'h5A};
        if (per_out.req) per_q <= per_out;
    end
    task automatic check(input string nm, input logic [36:0] seen, input logic [36:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic go(input logic [5:0] am, input logic [31:0] a, input logic [4:0] c, input logic [31:0] w);
        vme_bus_master_inst.cycle(am, a, c, w, 40, res, n, rd);
    endtask : go
    task automatic t_mem;
        logic [5:0]  am [8] = '{`AM_EXT_A, `AM_EXT_B, `AM_EXT_C, `AM_EXT_D, `AM_STD_A, `AM_STD_B, `AM_STD_C,
                                `AM_STD_D};
        logic [31:0] a;
        for (int i = 0; i < 8; i++) begin
            a = {(i < 4) ? 8'h00 : 8'hAB, 16'h0000, 8'(i * 4)};
            go(am[i], a, 5'b10000, 32'hA5C3_0000 | 32'(i));
            check("mem write", 37'(res), 37'h0_0000_0000);
            go(am[i], a, 5'b10100, 32'h0000_0000);
            check("mem read", rd, {5'h10, 32'hA5C3_0000 | 32'(i)});
            check("read latency", 37'(n), 37'h0_0000_0005);
        end
    endtask : t_mem
    task automatic t_half;
        go(`AM_EXT_A, 32'h0000_0000, 5'b11001, 32'h0000_C300);
        go(`AM_EXT_A, 32'h0000_0000, 5'b11100, 32'h0000_0000);
        check("upper half", {rd[36:32], rd[15:0]}, {16'h0000, 5'h1C, 16'hC3C3});
        go(`AM_EXT_A, 32'h0000_0002, 5'b11100, 32'h0000_0000);
        check("lower half", {rd[36:32], rd[15:0]}, {16'h0000, 5'h1C, 16'h0000});
        go(`AM_EXT_A, 32'h0000_0000, 5'b10100, 32'h0000_0000);
        check("merged word", rd, {5'h10, 32'hC3C3_0000});
    endtask : t_half
    task automatic t_quad;
        go(`AM_EXT_A, 32'h0000_1010, 5'b10000, 32'h1111_2222);
        go(`AM_EXT_A, 32'h0000_2010, 5'b10000, 32'h3333_4444);
        go(`AM_QUAD1, 32'h0000_0010, 5'b10100, 32'h0000_0000);
        check("quadrant one", rd, {5'h10, 32'h1111_2222});
        go(`AM_QUAD2, 32'h0000_0010, 5'b10100, 32'h0000_0000);
        check("quadrant two", rd, {5'h10, 32'h3333_4444});
    endtask : t_quad
    task automatic t_sio;
        go(`AM_SIO_A, 32'h0000_FF80, 5'b11010, 32'h0000_003C);
        check("io write", 37'(per_q), 37'({1'b1, 1'b1, 1'b0, 8'h81, 8'h3C}));
        check("io write ack", 37'(res), 37'h0);
        go(`AM_SIO_B, 32'h0000_FF80, 5'b11110, 32'h0000_0000);
        check("io read", {rd[36:32], rd[7:0]}, {24'h0, 5'h1E, 8'h5A});
        go(`AM_SIO_A, 32'h0000_FF80, 5'b10110, 32'h0000_0000);
        check("io longword refused", {32'(res), rd[36:32]}, {32'h2, 5'h1F});
        go(6'h3F, 32'h0000_0000, 5'b10100, 32'h0000_0000);
        check("unmapped refused", {32'(res), rd[36:32]}, {32'h2, 5'h1F});
    endtask : t_sio
    task automatic t_iack;
        irq_level   <= 3'd3;
        irq_pending <= 1'b1;
        go(6'h00, 32'h0000_0006, 5'b01110, 32'h0000_0000);
        check("vector", {rd[36:32], rd[7:0], per_q.iack, per_q.addr}, {15'h0, 5'h1E, 8'h5A, 1'b1, 8'h03});
        go(6'h00, 32'h0000_000A, 5'b01110, 32'h0000_0000);
        check("chain passed", {32'(res), rd[36:32]}, {32'h2, 5'h0F});
    endtask : t_iack
    task automatic t_tmo;
        int lim [8] = '{0, `TMO_SEL1_CYC, `TMO_SEL2_CYC, `TMO_SEL3_CYC, `TMO_SEL4_CYC, `TMO_SEL5_CYC,
                        `TMO_SEL6_CYC, `TMO_SEL7_CYC};
        for (int s = 1; s < 8; s++) begin
            tmo_sel <= 3'(s);
            vme_bus_master_inst.cycle(6'h3F, 32'h0000_0000, 5'b10100, 32'h0000_0000, 2000, res, n, rd);
            check("bus error", 37'(res), 37'h1);
            check("timeout span", 37'(n >= lim[s] && n <= lim[s] + 3), 37'h1);
        end
        tmo_sel <= 3'd0;
    endtask : t_tmo
    task automatic t_reset;
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (3) @(posedge core_clk);
        check("reset outputs", {dtack_oe_n, berr_oe_n, iackout_n, data_oe_n, per_out}, {7'h7F, 19'h0});
        check("reset data", 37'(data_o), 37'h0);
        reset <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask : t_reset
    task automatic final_report;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report
    initial begin
        reset       = 1'b0;
        tmo_sel     = 3'd0;
        irq_level   = 3'd0;
        irq_pending = 1'b0;
        // raise reset after time zero so every process sees its edge
        #1 reset    = 1'b1;
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        repeat (2) @(posedge core_clk);
        t_mem;
        t_half;
        t_quad;
        t_sio;
        t_iack;
        t_reset;
        t_tmo;
        final_report;
    end
    // the whole run needs under 6000 cycles
    initial begin
        #(100 * 20000);
        fail_count++;
        final_report;
    end
endmodule : tb_vme_slave_cycle_decoder
`default_nettype wire
